// ==== rtl/rcb_pkg.sv ====
// Package of the per-channel object bank: object indices, subindices,
// field widths, reset and factory values.
// Assumes one 100 MHz clock and an object access port driven by the
// fieldbus slave controller.
package rcb_pkg;

	// ==========================================================
	// Sizes
	localparam int          RCB_CHANNELS   = 4;
	localparam int          RCB_CAL_WORDS  = 6;

	// ==========================================================
	// Object indices
	localparam logic [3:0]  RCB_IDX_INPUT_HI   = 4'h6;
	localparam logic [3:0]  RCB_IDX_INPUT_LO   = 4'h0;
	localparam logic [3:0]  RCB_IDX_CFG_HI     = 4'h8;
	localparam logic [3:0]  RCB_IDX_INTERNAL   = 4'he;
	localparam logic [3:0]  RCB_IDX_FACTORY    = 4'hf;
	localparam logic [15:0] RCB_IDX_PROFILE    = 16'hf000;
	localparam logic [15:0] RCB_IDX_KEY_WORD   = 16'hf008;
	localparam logic [15:0] RCB_IDX_MOD_LIST   = 16'hf010;
	localparam logic [15:0] RCB_IDX_RESTORE    = 16'h1011;

	// ==========================================================
	// Subindices of the input object, then numbered subindices of the other objects
	localparam logic [7:0]  RCB_SUB_MAX        = 8'h00;
	localparam logic [7:0]  RCB_SUB_LOW        = 8'h01;
	localparam logic [7:0]  RCB_SUB_HIGH       = 8'h02;
	localparam logic [7:0]  RCB_SUB_ERR        = 8'h07;
	localparam logic [7:0]  RCB_SUB_VALID      = 8'h0f;
	localparam logic [7:0]  RCB_SUB_FLIP       = 8'h10;
	localparam logic [7:0]  RCB_SUB_RESULT     = 8'h11;
	localparam logic [7:0]  RCB_SUB_ONE        = 8'h01;
	localparam logic [7:0]  RCB_SUB_TWO        = 8'h02;
	localparam logic [7:0]  RCB_SUB_THREE      = 8'h03;
	localparam logic [7:0]  RCB_SUB_FOUR       = 8'h04;

	// ==========================================================
	// Maximum-subindex answers
	localparam logic [31:0] RCB_INPUT_MAX      = 32'h0000_0011;
	localparam logic [31:0] RCB_INTERNAL_MAX   = 32'h0000_0004;
	localparam logic [31:0] RCB_FACTORY_MAX    = 32'h0000_0006;
	localparam logic [31:0] RCB_PROFILE_MAX    = 32'h0000_0002;
	localparam logic [31:0] RCB_MOD_LIST_MAX   = 32'h0000_0004;
	localparam logic [31:0] RCB_RESTORE_MAX    = 32'h0000_0001;

	// ==========================================================
	// Constant contents and reset values
	localparam logic [15:0] RCB_INDEX_SPACING  = 16'h0010;
	localparam logic [15:0] RCB_CHANNEL_COUNT  = 16'h0004;
	localparam logic [31:0] RCB_PROFILE_ENTRY  = 32'h0000_0140;
	localparam logic [31:0] RCB_RESTORE_CODE   = 32'h6461_6f6c;
	localparam logic [31:0] RCB_WORD_RESET     = 32'h0000_0000;
	localparam logic [15:0] RCB_HALF_RESET     = 16'h0000;

	// Factory calibration, word k is subindex k+1; values are plain defaults
	localparam logic [RCB_CAL_WORDS-1:0][15:0] RCB_CAL_FACTORY = {
		16'h8000, 16'h8000, 16'h8000, 16'h0000, 16'h8000, 16'h0000};

	typedef struct packed {
		logic [RCB_CHANNELS-1:0]                         low;
		logic [RCB_CHANNELS-1:0]                         high;
		logic [RCB_CHANNELS-1:0]                         err;
		logic [RCB_CHANNELS-1:0]                         inval;
		logic [RCB_CHANNELS-1:0]                         flip;
		logic [RCB_CHANNELS-1:0][15:0]                   result;
		logic [RCB_CHANNELS-1:0][15:0]                   sres;
		logic [RCB_CHANNELS-1:0][15:0]                   lres;
		logic [RCB_CHANNELS-1:0][31:0]                   sraw;
		logic [RCB_CHANNELS-1:0][31:0]                   lraw;
		logic [RCB_CHANNELS-1:0][RCB_CAL_WORDS-1:0][15:0] cal;
		logic [31:0]                                     key_word;
		logic [31:0]                                     restore_key;
		logic [31:0]                                     rdata;
		logic                                            ack;
		logic                                            abort;
		logic                                            restored;
	} rcb_state_t;

endpackage

// ==== rtl/rcb_object_bank.sv ====
// Per-channel object bank of a four-channel resistance input module.
// Assumes the slave controller issues one object request at a time on
// the obj_* port and the converter front end posts one channel per strobe.
//
// Notes on behaviour
// - Underrange flag while below range
// - Overrange flag; with error means open sensor
// - Error flag whenever value invalid
// - Validity bit: zero valid, one invalid
// - Toggle bit inverts on each refresh
// - Signed 16-bit result, read-only, reset zero
// - Sensor resistance, 1/32 ohm, read-only
// - Lead resistance, 1/32 ohm, read-only
// - Two signed 32-bit raw readings, read-only
// - Writable factory offsets and gains per channel
// - Profile reports spacing sixteen, four channels
// - Restore key brings back factory values and clears the key word
`timescale 1ns/1ps

module rcb_object_bank
	import rcb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	// Converter front end
	input  wire logic        upd_stb,
	input  wire logic [1:0]  upd_chan,
	input  wire logic [15:0] upd_result,
	input  wire logic        upd_below,
	input  wire logic        upd_above,
	input  wire logic        upd_open,
	input  wire logic        upd_bad,
	input  wire logic [31:0] upd_sensor_raw,
	input  wire logic [15:0] upd_sensor_res,
	input  wire logic [31:0] upd_lead_raw,
	input  wire logic [15:0] upd_lead_res,
	// Object access
	input  wire logic        obj_rd,
	input  wire logic        obj_wr,
	input  wire logic [15:0] obj_index,
	input  wire logic [7:0]  obj_sub,
	input  wire logic [31:0] obj_wdata,
	output logic [31:0]      obj_rdata,
	output logic             obj_ack,
	output logic             obj_abort,
	// Process image
	output logic [3:0]       range_low_flag,
	output logic [3:0]       range_high_flag,
	output logic [3:0]       invalid_data_flag,
	output logic [3:0]       block_validity_bit,
	output logic [3:0]       update_flip_bit,
	output logic [63:0]      channel_result,
	output logic [3:0][15:0] factory_cal_word0,
	output logic [3:0][15:0] factory_cal_word1,
	output logic             restore_done
);

	// ==========================================================
	// State
	rcb_state_t state_reg;
	rcb_state_t state_next;

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [1:0]  ch;
		logic        ch_ok;
		logic        found;
		logic        writable;
		logic [31:0] rd;
		int          k;
		logic        post_fault;
		logic        post_high;
		logic        hit_input;
		logic        hit_internal;
		logic        hit_factory;
		logic        hit_profile;
		logic        hit_key;
		logic        hit_list;
		logic        hit_restore;
		logic        req;

		ch       = obj_index[5:4];
		ch_ok    = (obj_index[7:6] == 2'b00);
		found    = 1'b0;
		writable = 1'b0;
		rd       = RCB_WORD_RESET;
		k        = 0;
		post_fault = upd_bad | upd_open;
		post_high  = upd_above | upd_open;
		req        = obj_rd | obj_wr;

		// ==========================================================
		// Object address decode; channel objects need bits 7:6 clear
		hit_input    = ch_ok && obj_index[15:12] == RCB_IDX_INPUT_HI
			&& obj_index[11:8] == RCB_IDX_INPUT_LO && obj_index[3:0] == RCB_IDX_INPUT_LO;
		hit_internal = ch_ok && obj_index[15:12] == RCB_IDX_CFG_HI
			&& obj_index[11:8] == RCB_IDX_INPUT_LO && obj_index[3:0] == RCB_IDX_INTERNAL;
		hit_factory  = ch_ok && obj_index[15:12] == RCB_IDX_CFG_HI
			&& obj_index[11:8] == RCB_IDX_INPUT_LO && obj_index[3:0] == RCB_IDX_FACTORY;
		// Fixed objects match the whole index
		hit_profile  = (obj_index == RCB_IDX_PROFILE);
		hit_key      = (obj_index == RCB_IDX_KEY_WORD) && (obj_sub == RCB_SUB_MAX);
		hit_list     = (obj_index == RCB_IDX_MOD_LIST);
		hit_restore  = (obj_index == RCB_IDX_RESTORE);

		state_next          = state_reg;
		state_next.ack      = 1'b0;
		state_next.abort    = 1'b0;
		state_next.restored = 1'b0;

		// ==========================================================
		// Measurement refresh, whole set at once
		if (upd_stb)
		begin
			state_next.low[upd_chan]    = upd_below;
			state_next.high[upd_chan]   = post_high;
			state_next.err[upd_chan]    = post_fault;
			state_next.inval[upd_chan]  = post_fault;
			state_next.flip[upd_chan]   = ~state_reg.flip[upd_chan];
			state_next.result[upd_chan] = upd_result;
			state_next.sres[upd_chan]   = upd_sensor_res;
			state_next.lres[upd_chan]   = upd_lead_res;
			state_next.sraw[upd_chan]   = upd_sensor_raw;
			state_next.lraw[upd_chan]   = upd_lead_raw;
		end

		// ==========================================================
		// Object decode
		if (hit_input)
		begin
			found = 1'b1;
			case (obj_sub)
				RCB_SUB_MAX:    rd = RCB_INPUT_MAX;
				RCB_SUB_LOW:    rd = {31'h0, state_reg.low[ch]};
				RCB_SUB_HIGH:   rd = {31'h0, state_reg.high[ch]};
				RCB_SUB_ERR:    rd = {31'h0, state_reg.err[ch]};
				RCB_SUB_VALID:  rd = {31'h0, state_reg.inval[ch]};
				RCB_SUB_FLIP:   rd = {31'h0, state_reg.flip[ch]};
				RCB_SUB_RESULT: rd = {{16{state_reg.result[ch][15]}}, state_reg.result[ch]};
				default:        found = 1'b0;
			endcase
		end
		else if (hit_internal)
		begin
			found = 1'b1;
			case (obj_sub)
				RCB_SUB_MAX:   rd = RCB_INTERNAL_MAX;
				RCB_SUB_ONE:   rd = state_reg.sraw[ch];
				RCB_SUB_TWO:   rd = {16'h0, state_reg.sres[ch]};
				RCB_SUB_THREE: rd = state_reg.lraw[ch];
				RCB_SUB_FOUR:  rd = {16'h0, state_reg.lres[ch]};
				default:       found = 1'b0;
			endcase
		end
		else if (hit_factory)
		begin
			if (obj_sub == RCB_SUB_MAX)
			begin
				found = 1'b1;
				rd    = RCB_FACTORY_MAX;
			end
			else if (obj_sub <= RCB_FACTORY_MAX[7:0])
			begin
				found    = 1'b1;
				writable = 1'b1;
				k        = int'(obj_sub) - 1;
				// Offsets sign-extend, gains zero-extend
				if (obj_sub == RCB_SUB_ONE || obj_sub == RCB_SUB_THREE)
					rd = {{16{state_reg.cal[ch][k][15]}}, state_reg.cal[ch][k]};
				else
					rd = {16'h0, state_reg.cal[ch][k]};
				if (obj_wr)
					state_next.cal[ch][k] = obj_wdata[15:0];
			end
		end
		else if (hit_profile)
		begin
			found = 1'b1;
			case (obj_sub)
				RCB_SUB_MAX: rd = RCB_PROFILE_MAX;
				RCB_SUB_ONE: rd = {16'h0, RCB_INDEX_SPACING};
				RCB_SUB_TWO: rd = {16'h0, RCB_CHANNEL_COUNT};
				default:     found = 1'b0;
			endcase
		end
		else if (hit_key)
		begin
			found    = 1'b1;
			writable = 1'b1;
			rd       = state_reg.key_word;
			if (obj_wr)
				state_next.key_word = obj_wdata;
		end
		else if (hit_list)
		begin
			if (obj_sub == RCB_SUB_MAX)
			begin
				found = 1'b1;
				rd    = RCB_MOD_LIST_MAX;
			end
			else if (obj_sub <= RCB_MOD_LIST_MAX[7:0])
			begin
				found = 1'b1;
				rd    = RCB_PROFILE_ENTRY;
			end
		end
		else if (hit_restore)
		begin
			found = 1'b1;
			case (obj_sub)
				RCB_SUB_MAX: rd = RCB_RESTORE_MAX;
				RCB_SUB_ONE:
				begin
					writable = 1'b1;
					rd       = state_reg.restore_key;
					if (obj_wr)
					begin
						state_next.restore_key = obj_wdata;
						// Only the exact key brings back delivery values
						if (obj_wdata == RCB_RESTORE_CODE)
						begin
							for (int c = 0; c < RCB_CHANNELS; c++)
								state_next.cal[c] = RCB_CAL_FACTORY;
							state_next.key_word    = RCB_WORD_RESET;
							state_next.restored    = 1'b1;
						end
					end
				end
				default:     found = 1'b0;
			endcase
		end

		// ==========================================================
		// Answer one cycle after the request
		if (req)
		begin
			state_next.ack   = 1'b1;
			state_next.abort = ~found | (obj_wr & ~writable);
			if (obj_rd && found)
				state_next.rdata = rd;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg.low         <= '0;
			state_reg.high        <= '0;
			state_reg.err         <= '0;
			state_reg.inval       <= '0;
			state_reg.flip        <= '0;

			// Calibration starts at delivery values
			for (int c = 0; c < RCB_CHANNELS; c++)
			begin
				state_reg.result[c] <= RCB_HALF_RESET;
				state_reg.sres[c]   <= RCB_HALF_RESET;
				state_reg.lres[c]   <= RCB_HALF_RESET;
				state_reg.sraw[c]   <= RCB_WORD_RESET;
				state_reg.lraw[c]   <= RCB_WORD_RESET;
				state_reg.cal[c]    <= RCB_CAL_FACTORY;
			end
			state_reg.key_word    <= RCB_WORD_RESET;
			state_reg.restore_key <= RCB_WORD_RESET;
			state_reg.rdata       <= RCB_WORD_RESET;
			state_reg.ack         <= 1'b0;
			state_reg.abort       <= 1'b0;
			state_reg.restored    <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	always_comb
	begin
		obj_rdata          = state_reg.rdata;
		obj_ack            = state_reg.ack;
		obj_abort          = state_reg.abort;
		range_low_flag     = state_reg.low;
		range_high_flag    = state_reg.high;
		invalid_data_flag  = state_reg.err;
		block_validity_bit = state_reg.inval;
		update_flip_bit    = state_reg.flip;
		channel_result     = state_reg.result;
		restore_done       = state_reg.restored;
		// Calibration words for the converter path
		for (int c = 0; c < RCB_CHANNELS; c++)
		begin
			factory_cal_word0[c] = state_reg.cal[c][0];
			factory_cal_word1[c] = state_reg.cal[c][1];
		end
	end

endmodule

// ==== tb/rcb_object_bank_chk.sv ====
// Checker of the object bank: answer timing and the per-channel update set.
// Assumes it is bound to rcb_object_bank and sees only its ports.
`timescale 1ns/1ps

module rcb_object_bank_chk
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        upd_stb,
	input wire logic [1:0]  upd_chan,
	input wire logic [15:0] upd_result,
	input wire logic        upd_below,
	input wire logic        upd_above,
	input wire logic        upd_open,
	input wire logic        upd_bad,
	input wire logic        obj_rd,
	input wire logic        obj_wr,
	input wire logic        obj_ack,
	input wire logic        obj_abort,
	input wire logic [3:0]  range_low_flag,
	input wire logic [3:0]  range_high_flag,
	input wire logic [3:0]  invalid_data_flag,
	input wire logic [3:0]  block_validity_bit,
	input wire logic [3:0]  update_flip_bit,
	input wire logic [63:0] channel_result
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_ack; (obj_rd || obj_wr) |=> obj_ack; endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_ack_src; obj_ack |-> $past(obj_rd || obj_wr); endproperty
	a_ack_src: assert property (p_ack_src) else $error("answer without request");
	property p_abort; obj_abort |-> obj_ack; endproperty
	a_abort: assert property (p_abort) else $error("refusal without answer");
	property p_flip;
		upd_stb |=> (update_flip_bit ^ $past(update_flip_bit)) == (4'h1 << $past(upd_chan));
	endproperty
	a_flip: assert property (p_flip) else $error("toggle bit wrong");
	property p_hold;
		!upd_stb |=> $stable({update_flip_bit, range_low_flag, range_high_flag, invalid_data_flag,
			block_validity_bit, channel_result});
	endproperty
	a_hold: assert property (p_hold) else $error("image changed without post");
	property p_flags;
		upd_stb |=> {range_low_flag[$past(upd_chan)], range_high_flag[$past(upd_chan)],
			invalid_data_flag[$past(upd_chan)]} == $past({upd_below, upd_above || upd_open,
			upd_bad || upd_open});
	endproperty
	a_flags: assert property (p_flags) else $error("range or error flag wrong");
	property p_valid;
		upd_stb |=> block_validity_bit[$past(upd_chan)] == $past(upd_bad || upd_open);
	endproperty
	a_valid: assert property (p_valid) else $error("validity bit wrong");
	property p_result;
		upd_stb |=> channel_result[{$past(upd_chan), 4'h0} +: 16] == $past(upd_result);
	endproperty
	a_result: assert property (p_result) else $error("channel result wrong");
	c_open: cover property (upd_stb && upd_open);
	c_refuse: cover property (obj_ack && obj_abort);
	c_found: cover property (obj_ack && !obj_abort);
endmodule

bind rcb_object_bank rcb_object_bank_chk chk_u (.clk, .nrst, .upd_stb, .upd_chan,
	.upd_result, .upd_below, .upd_above, .upd_open, .upd_bad, .obj_rd, .obj_wr, .obj_ack,
	.obj_abort, .range_low_flag, .range_high_flag, .invalid_data_flag, .block_validity_bit,
	.update_flip_bit, .channel_result);

// ==== tb/rcb_master.sv ====
// Fieldbus side model: one object request at a time, answer taken with ack.
// Assumes the bank answers one cycle after taking a request.
`timescale 1ns/1ps

module rcb_master
(
	input  wire logic        clk,
	output logic             obj_rd,
	output logic             obj_wr,
	output logic [15:0]      obj_index,
	output logic [7:0]       obj_sub,
	output logic [31:0]      obj_wdata,
	input  wire logic [31:0] obj_rdata,
	input  wire logic        obj_ack,
	input  wire logic        obj_abort
);
	initial {obj_rd, obj_wr, obj_index, obj_sub, obj_wdata} = '0;
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, output logic [31:0] rd, output logic ab);
		int n;
		@(posedge clk) #1;
		{obj_wr, obj_rd, obj_index, obj_sub, obj_wdata} = {wr, !wr, idx, sub, wd};
		@(posedge clk) #1;
		// Released lines show garbage, not the old value
		{obj_wr, obj_rd, obj_index, obj_sub, obj_wdata} = {2'b00, ~{idx, sub, wd}};
		n = 0;
		while (obj_ack !== 1'b1 && n < 4)
		begin
			@(posedge clk) #1;
			n++;
		end
		rd = obj_rdata;
		ab = (obj_ack === 1'b1) ? obj_abort : 1'bx;
	endtask
endmodule

// ==== tb/rcb_object_bank_bench.sv ====
// Testbench of the object bank: LFSR-driven posts to channels 0 to 3 in turn, object reads and writes.
// Assumes rcb_master as the fieldbus side and the bound checker.
`timescale 1ns/1ps

module rcb_object_bank_bench;
	import rcb_pkg::*;
	logic        clk, nrst, upd_stb, upd_below, upd_above, upd_open, upd_bad;
	logic        obj_rd, obj_wr, obj_ack, obj_abort, restore_done;
	logic [1:0]  upd_chan;
	logic [15:0] upd_result, upd_sensor_res, upd_lead_res, obj_index;
	logic [7:0]  obj_sub;
	logic [31:0] upd_sensor_raw, upd_lead_raw, obj_wdata, obj_rdata, seed;
	logic [3:0]  low_f, high_f, err_f, val_f, flip_f;
	logic [63:0] res_img;
	logic [3:0][15:0] cal0, cal1;
	logic [31:0] mdl [4][10];
	logic [7:0]  subs [10] = '{8'h01, 8'h02, 8'h07, 8'h0f, 8'h10, 8'h11, 8'h01, 8'h02,
		8'h03, 8'h04};
	int          failures, check_count, n_rest;
	rcb_object_bank dut_u (.clk, .nrst, .upd_stb, .upd_chan, .upd_result, .upd_below,
		.upd_above, .upd_open, .upd_bad, .upd_sensor_raw, .upd_sensor_res, .upd_lead_raw,
		.upd_lead_res, .obj_rd, .obj_wr, .obj_index, .obj_sub, .obj_wdata, .obj_rdata,
		.obj_ack, .obj_abort, .range_low_flag(low_f), .range_high_flag(high_f),
		.invalid_data_flag(err_f), .block_validity_bit(val_f), .update_flip_bit(flip_f),
		.channel_result(res_img), .factory_cal_word0(cal0), .factory_cal_word1(cal1),
		.restore_done);
	rcb_master m_u (.clk, .obj_rd, .obj_wr, .obj_index, .obj_sub, .obj_wdata, .obj_rdata,
		.obj_ack, .obj_abort);
	// ==========================================================
	// Tasks
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic eab, input logic [31:0] exp);
		logic [31:0] rd;
		logic ab;
		m_u.xfer(wr, idx, sub, wd, rd, ab);
		check_count++;
		if (ab !== eab || (!wr && !eab && rd !== exp))
		begin
			failures++;
			$display("Error obj %h:%h expected %h/%b seen %h/%b", idx, sub, exp, eab, rd, ab);
		end
	endtask
	task automatic post(input int c);
		@(posedge clk) #1;
		seed = lfsr(seed);
		{upd_stb, upd_chan, upd_below, upd_above, upd_open, upd_bad} = {1'b1, c[1:0], seed[3:0]};
		{upd_result, upd_sensor_res} = seed;
		upd_sensor_raw = ~seed;
		upd_lead_raw = {seed[7:0], seed[31:8]};
		upd_lead_res = seed[27:12];
		mdl[c][0] = 32'(seed[3]);
		mdl[c][1] = 32'(seed[2] | seed[1]);
		mdl[c][2] = 32'(seed[0] | seed[1]);
		mdl[c][3] = 32'(seed[0] | seed[1]);
		mdl[c][4] = 32'(!mdl[c][4][0]);
		mdl[c][5] = {{16{seed[31]}}, seed[31:16]};
		mdl[c][6] = ~seed;
		mdl[c][7] = 32'(seed[15:0]);
		mdl[c][8] = upd_lead_raw;
		mdl[c][9] = 32'(seed[27:12]);
		@(posedge clk) #1 upd_stb = 1'b0;
	endtask
	task automatic img(input int c);
		logic [20:0] e, s;
		e = {mdl[c][0][0], mdl[c][1][0], mdl[c][2][0], mdl[c][3][0], mdl[c][4][0],
			mdl[c][5][15:0]};
		s = {low_f[c], high_f[c], err_f[c], val_f[c], flip_f[c], res_img[c*16 +: 16]};
		check_count++;
		if (s !== e)
		begin
			failures++;
			$display("Error image ch%0d expected %h seen %h", c, e, s);
		end
	endtask
	task automatic sweep;
		for (int c = 0; c < 4; c++)
		begin
			img(c);
			for (int j = 0; j < 10; j++)
				acc(1'b0, (j < 6 ? 16'h6000 : 16'h800e) | 16'(c * 16), subs[j], '0, 1'b0,
					mdl[c][j]);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// Stimulus
	always #5 clk = ~clk;
	always @(negedge clk) if (restore_done === 1'b1) n_rest++;
	initial
	begin
		#100000;
		failures++;
		report_and_stop;
	end
	initial
	begin
		{clk, nrst, upd_stb, upd_chan, upd_below, upd_above, upd_open, upd_bad} = '0;
		{upd_result, upd_sensor_res, upd_lead_res, upd_sensor_raw, upd_lead_raw} = '0;
		seed = 32'h7f10ab86;
		mdl = '{default: '0};
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		sweep;
		acc(1'b0, RCB_IDX_PROFILE, 8'h01, '0, 1'b0, 32'h10);
		acc(1'b0, RCB_IDX_PROFILE, 8'h02, '0, 1'b0, 32'h4);
		acc(1'b0, RCB_IDX_MOD_LIST, 8'h03, '0, 1'b0, 32'h140);
		for (int k = 0; k < 12; k++)
			post(k % 4);
		sweep;
		acc(1'b1, 16'h6030, 8'h11, 32'h5, 1'b1, '0);
		acc(1'b1, 16'h801e, 8'h02, 32'h5, 1'b1, '0);
		acc(1'b0, 16'h6040, 8'h01, '0, 1'b1, '0);
		sweep;
		acc(1'b0, 16'h803f, 8'h02, '0, 1'b0, 32'h8000);
		acc(1'b0, 16'h801f, 8'h00, '0, 1'b0, 32'h6);
		acc(1'b1, 16'h803f, 8'h01, 32'hffffff00, 1'b0, '0);
		acc(1'b1, 16'h803f, 8'h02, 32'h1234, 1'b0, '0);
		acc(1'b1, 16'h801f, 8'h06, 32'h0abc, 1'b0, '0);
		acc(1'b0, 16'h803f, 8'h01, '0, 1'b0, 32'hffffff00);
		acc(1'b0, 16'h801f, 8'h06, '0, 1'b0, 32'h0abc);
		acc(1'b1, RCB_IDX_KEY_WORD, 8'h00, 32'ha5a5a5a5, 1'b0, '0);
		acc(1'b1, RCB_IDX_RESTORE, 8'h01, RCB_RESTORE_CODE ^ 32'h1, 1'b0, '0);
		acc(1'b0, 16'h803f, 8'h02, '0, 1'b0, 32'h1234);
		acc(1'b1, RCB_IDX_RESTORE, 8'h01, RCB_RESTORE_CODE, 1'b0, '0);
		acc(1'b0, 16'h803f, 8'h02, '0, 1'b0, 32'h8000);
		acc(1'b0, 16'h801f, 8'h06, '0, 1'b0, 32'h8000);
		acc(1'b0, RCB_IDX_KEY_WORD, 8'h00, '0, 1'b0, '0);
		check_count++;
		if (n_rest != 1 || cal1[3] !== 16'h8000 || cal0[3] !== 16'h0000)
		begin
			failures++;
			$display("Error restore expected 1/8000/0000 seen %0d/%h/%h", n_rest, cal1[3], cal0[3]);
		end
		report_and_stop;
	end
endmodule
